// ==== core/sensor_telegram_interpreter.sv ====
// telegram parser, reply generator and cyclic input image of the sensor
`timescale 1ns/100ps
`default_nettype none
module sensor_telegram_interpreter (
    // clock and reset
    input  wire logic                        clock_in,
    input  wire logic                        rst_in,
    // tcp byte streams
    input  wire telegram_pkg::byte_stream_t  rx_in,
    output logic                             rx_ready_out,
    output telegram_pkg::byte_stream_t       tx_out,
    input  wire logic                        tx_ready_in,
    input  wire logic                        conn_up_in,
    // sensor side
    input  wire logic                        on_request_in,
    input  wire logic                        job_lock_in,
    input  wire telegram_pkg::sensor_status_t status_in,
    input  wire telegram_pkg::result_t       result_in,
    input  wire telegram_pkg::job_write_t    job_wr_in,
    output logic                             stats_clear_out,
    output logic [15:0]                      result_count_out,
    // cyclic image
    input  wire logic [7:0]                  image_addr_in,
    output logic [7:0]                       image_byte_out,
    output logic [7:0]                       assembly_id_out,
    output logic [15:0]                      tcp_port_out
);
    import telegram_pkg::*;

    typedef struct packed {
        logic [7:0]  c0;
        logic [7:0]  c1;
        logic [1:0]  ncnt;
        logic [7:0]  job;
        logic [1:0]  jchars;
        logic        jerr;
        logic        cmd_pend;
        logic [15:0] cmd;
        logic        job_ok;
        logic [4:0]  job_sel;
        logic        busy;
        msg_t        msg;
        logic [4:0]  idx;
        logic        rd_next;
        logic        rd_pend;
        logic [15:0] rid;
        logic [15:0] rlen;
        logic        pass;
        logic        fail;
        logic [31:0] rcode;
        logic [31:0] ecode;
        logic [15:0] rcount;
        logic        clr;
        logic        rx_rdy;
        logic [7:0]  img;
        logic [7:0]  asm_id;
        logic [15:0] port;
    } state_t;

    state_t      s;
    state_t      n;
    logic [7:0]  job_mem [0:JOB_WORDS-1];
    logic        tx_push;
    logic        tx_ready;
    logic        tx_last;
    logic [7:0]  tx_char;
    logic [4:0]  body;
    logic [3:0]  nib;
    logic        is_hex;
    logic [15:0] word;
    logic [63:0] codes;
    int          j;
    int          k;

    // ----------------------------------------------------------------
    // job store
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (job_wr_in.valid) begin
            job_mem[job_wr_in.addr] <= job_wr_in.data;
        end
    end

    function automatic logic [7:0] hex_char(input logic [3:0] v);
        return (v < HEX_TEN[3:0]) ? CH_ZERO + {4'h0, v} : CH_UP_A + {4'h0, v} - HEX_TEN;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n       = s;
        n.clr   = 1'b0;
        j       = int'(s.idx);
        k       = 0;
        nib     = 4'h0;
        is_hex  = 1'b0;
        word    = 16'h0000;
        codes   = {s.rcode, s.ecode};
        tx_char = 8'h00;
        tx_last = 1'b0;

        // receive side: two code bytes then hex parameter characters
        if (rx_in.valid && s.rx_rdy) begin
            if (rx_in.data == CH_CR || rx_in.data == CH_LF) begin
                if (s.ncnt != 2'd0) begin
                    n.cmd_pend = 1'b1;
                    n.cmd      = (s.ncnt == 2'd1) ? {s.c0, 8'h00} : {s.c0, s.c1};
                    n.job_ok   = !s.jerr && s.jchars != 2'd0 && !job_lock_in
                                 && s.job >= JOB_FIRST && s.job <= JOB_LAST;
                    n.job_sel  = 5'(s.job - JOB_FIRST);
                end
                n.ncnt   = 2'd0;
                n.job    = 8'h00;
                n.jchars = 2'd0;
                n.jerr   = 1'b0;
            end else begin
                if (rx_in.data >= CH_ZERO && rx_in.data <= CH_NINE) begin
                    is_hex = 1'b1;
                    nib    = 4'(rx_in.data - CH_ZERO);
                end else if (rx_in.data >= CH_UP_A && rx_in.data <= CH_UP_F) begin
                    is_hex = 1'b1;
                    nib    = 4'(rx_in.data - CH_UP_A + HEX_TEN);
                end else if (rx_in.data >= CH_LO_A && rx_in.data <= CH_LO_F) begin
                    is_hex = 1'b1;
                    nib    = 4'(rx_in.data - CH_LO_A + HEX_TEN);
                end
                unique case (s.ncnt)
                    2'd0: n.c0 = rx_in.data;
                    2'd1: n.c1 = rx_in.data;
                    default: begin
                        if (!is_hex || s.jchars == 2'd2) begin
                            n.jerr = 1'b1;
                        end else begin
                            n.job    = {s.job[3:0], nib};
                            n.jchars = s.jchars + 2'd1;
                        end
                    end
                endcase
                if (s.ncnt != 2'd3) begin
                    n.ncnt = s.ncnt + 2'd1;
                end
            end
        end

        // reply character for the current position
        unique case (s.msg)
            MSG_ACK:    body = ACK_LEN;
            MSG_RESULT: body = RD_LEN;
            MSG_BINARY: body = BD_LEN;
            MSG_ERROR:  body = ERR_LEN;
        endcase
        if (s.idx == body) begin
            tx_char = CH_CR;
        end else if (s.idx == body + 5'd1) begin
            tx_char = CH_LF;
            tx_last = 1'b1;
        end else begin
            unique case (s.msg)
                MSG_ACK:   tx_char = ACK_TEXT[8 * (int'(ACK_LEN) - 1 - j) +: 8];
                MSG_ERROR: tx_char = ERR_TEXT[8 * (int'(ERR_LEN) - 1 - j) +: 8];
                MSG_RESULT: begin
                    if (j < RD_CODE_AT) begin
                        tx_char = RD_TEXT[8 * (PREFIX_LEN - 1 - j) +: 8];
                    end else if (j < RD_COMMA_AT) begin
                        k       = j - RD_CODE_AT;
                        tx_char = hex_char(s.rcode[4 * (2 * CODE_BYTES - 1 - k) +: 4]);
                    end else if (j == RD_COMMA_AT) begin
                        tx_char = CH_COMMA;
                    end else begin
                        k       = j - RD_EXP_AT;
                        tx_char = hex_char(s.ecode[4 * (2 * CODE_BYTES - 1 - k) +: 4]);
                    end
                end
                MSG_BINARY: begin
                    if (j < PREFIX_LEN) begin
                        tx_char = BD_TEXT[8 * (PREFIX_LEN - 1 - j) +: 8];
                    end else if (j == PREFIX_LEN) begin
                        tx_char = hex_char(JOB_BYTES[7:4]);
                    end else if (j < BD_COMMA_AT) begin
                        tx_char = hex_char(JOB_BYTES[3:0]);
                    end else if (j == BD_COMMA_AT) begin
                        tx_char = CH_COMMA;
                    end else begin
                        k       = j - BD_DATA_AT;
                        tx_char = job_mem[{s.job_sel, 2'(k)}];
                    end
                end
            endcase
        end
        tx_push = s.busy;

        // reply sequencer: command answers first, then pending results
        if (!s.busy) begin
            if (s.cmd_pend) begin
                n.cmd_pend = 1'b0;
                n.idx      = 5'd0;
                unique case (s.cmd)
                    CMD_CLEAR_STATS: begin
                        n.clr    = 1'b1;
                        n.rcount = 16'h0000;
                        n.msg    = MSG_ACK;
                        n.busy   = 1'b1;
                    end
                    CMD_GET_RESULT: begin
                        n.msg     = MSG_ACK;
                        n.rd_next = 1'b1;
                        n.busy    = 1'b1;
                    end
                    CMD_JOB_LOAD: begin
                        n.msg  = s.job_ok ? MSG_BINARY : MSG_ERROR;
                        n.busy = 1'b1;
                    end
                    default: n.busy = 1'b0;
                endcase
            end else if (s.rd_pend) begin
                n.rd_pend = 1'b0;
                n.msg     = MSG_RESULT;
                n.idx     = 5'd0;
                n.busy    = 1'b1;
            end
        end else if (tx_ready) begin
            n.idx = s.idx + 5'd1;
            if (tx_last) begin
                n.idx = 5'd0;
                if (s.rd_next) begin
                    n.rd_next = 1'b0;
                    n.msg     = MSG_RESULT;
                end else begin
                    n.busy = 1'b0;
                end
            end
        end

        // results: a new one wins over a clear in the same cycle
        if (!conn_up_in) begin
            n.rd_pend = 1'b0;
        end
        if (result_in.valid) begin
            n.rid    = s.rid + 16'h0001;
            n.rlen   = PAYLOAD_LEN;
            n.pass   = result_in.pass;
            n.fail   = result_in.fail;
            n.rcode  = result_in.read_code;
            n.ecode  = result_in.expected_code;
            n.rcount = n.rcount + 16'h0001;
            if (conn_up_in && !on_request_in) begin
                n.rd_pend = 1'b1;
            end
        end
        n.rx_rdy = !n.cmd_pend;

        // cyclic image read port, even offsets hold the low byte
        unique case (image_addr_in[7:1])
            IMG_STATUS[7:1]: begin
                word[ST_SETUP]   = status_in.setup;
                word[ST_BUSY]    = status_in.busy;
                word[ST_TRIGGER] = status_in.trigger_ready;
            end
            IMG_JOB[7:1]:    word = status_in.running_job_number;
            IMG_TEMP[7:1]:   word = status_in.temperature;
            IMG_ALARM[7:1]:  word = status_in.alarm;
            IMG_RESULT[7:1]: begin
                word[RES_PASS] = s.pass;
                word[RES_FAIL] = s.fail;
            end
            IMG_ID[7:1]:     word = s.rid;
            IMG_LEN[7:1]:    word = s.rlen;
            default:         word = 16'h0000;
        endcase
        n.img = image_addr_in[0] ? word[15:8] : word[7:0];
        if (image_addr_in >= IMG_DATA && image_addr_in <= IMG_DATA_LAST) begin
            n.img = 8'h00;
            if (16'(image_addr_in - IMG_DATA) < s.rlen) begin
                k     = int'(image_addr_in - IMG_DATA);
                n.img = codes[8 * (2 * CODE_BYTES - 1 - k) +: 8];
            end
        end
        n.asm_id = ASSEMBLY_ID;
        n.port   = TCP_PORT;
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // transmit buffer and outputs
    // ----------------------------------------------------------------
    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) tx_fifo (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .in_valid_in   (tx_push),
        .in_data_in    (tx_char),
        .in_ready_out  (tx_ready),
        .out_valid_out (tx_out.valid),
        .out_data_out  (tx_out.data),
        .out_ready_in  (tx_ready_in)
    );

    assign rx_ready_out     = s.rx_rdy;
    assign stats_clear_out  = s.clr;
    assign result_count_out = s.rcount;
    assign image_byte_out   = s.img;
    assign assembly_id_out  = s.asm_id;
    assign tcp_port_out     = s.port;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence get_taken;
        !s.busy && s.cmd_pend && s.cmd == CMD_GET_RESULT;
    endsequence
    sequence ack_armed;
        s.busy && s.msg == MSG_ACK && s.rd_next;
    endsequence
    sequence ack_ending;
        s.busy && s.rd_next && tx_ready && tx_last;
    endsequence

    a_id_step: assert property (result_in.valid |=> s.rid == $past(s.rid) + 16'h0001)
        else $error("result_sequence_id did not step by one");
    a_len_report: assert property (result_in.valid |=> s.rlen == PAYLOAD_LEN)
        else $error("result length not reported");
    a_image_id: assert property (image_addr_in == IMG_ID |=> image_byte_out == $past(s.rid[7:0]))
        else $error("image id byte wrong");
    a_port_fixed: assert property (!$past(rst_in) |-> tcp_port_out == TCP_PORT && assembly_id_out == ASSEMBLY_ID)
        else $error("port or assembly id wrong");
    a_term_ends: assert property (rx_in.valid && s.rx_rdy && s.ncnt != 2'd0 && (rx_in.data == CH_CR || rx_in.data == CH_LF) |=> s.cmd_pend && !rx_ready_out)
        else $error("terminator did not close telegram");
    a_code_taken: assert property (rx_in.valid && s.rx_rdy && s.ncnt == 2'd1 && rx_in.data != CH_CR && rx_in.data != CH_LF |=> s.c1 == $past(rx_in.data) && s.ncnt == 2'd2)
        else $error("second code byte not taken");
    a_clear_ack: assert property (!s.busy && s.cmd_pend && s.cmd == CMD_CLEAR_STATS |=> stats_clear_out && s.msg == MSG_ACK && s.busy ##1 !stats_clear_out)
        else $error("clear statistics not acknowledged");
    a_get_chain: assert property (get_taken |=> ack_armed)
        else $error("get data not acknowledged");
    a_get_result: assert property (ack_ending |=> s.busy && s.msg == MSG_RESULT && s.idx == 5'd0)
        else $error("result telegram does not follow acknowledge");
    a_auto_result: assert property (result_in.valid && conn_up_in && !on_request_in |=> s.rd_pend || (s.busy && s.msg == MSG_RESULT))
        else $error("continuous result not scheduled");
    a_on_request: assert property (on_request_in && !s.rd_pend |=> !s.rd_pend)
        else $error("automatic result in on-request mode");
    a_job_reply: assert property (!s.busy && s.cmd_pend && s.cmd == CMD_JOB_LOAD |=> s.busy && s.msg == ($past(s.job_ok) ? MSG_BINARY : MSG_ERROR))
        else $error("job download reply kind wrong");
endmodule
`default_nettype wire

// ==== core/telegram_pkg.sv ====
// shared constants and carrier types of the sensor telegram interpreter
package telegram_pkg;

    // ----------------------------------------------------------------
    // identity of the link and the cyclic image
    // ----------------------------------------------------------------
    localparam logic [7:0]  ASSEMBLY_ID     = 8'h66;
    localparam logic [15:0] TCP_PORT        = 16'hC350;

    // ----------------------------------------------------------------
    // characters and command codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  CH_CR           = 8'h0D;
    localparam logic [7:0]  CH_LF           = 8'h0A;
    localparam logic [7:0]  CH_COMMA        = 8'h2C;
    localparam logic [7:0]  CH_ZERO         = 8'h30;
    localparam logic [7:0]  CH_NINE         = 8'h39;
    localparam logic [7:0]  CH_UP_A         = 8'h41;
    localparam logic [7:0]  CH_UP_F         = 8'h46;
    localparam logic [7:0]  CH_LO_A         = 8'h61;
    localparam logic [7:0]  CH_LO_F         = 8'h66;
    localparam logic [7:0]  HEX_TEN         = 8'h0A;
    localparam logic [15:0] CMD_CLEAR_STATS = 16'h4353;
    localparam logic [15:0] CMD_GET_RESULT  = 16'h4744;
    localparam logic [15:0] CMD_JOB_LOAD    = 16'h474A;

    // ----------------------------------------------------------------
    // image byte offsets and bit positions
    // ----------------------------------------------------------------
    localparam logic [7:0]  IMG_STATUS      = 8'h00;
    localparam logic [7:0]  IMG_JOB         = 8'h02;
    localparam logic [7:0]  IMG_TEMP        = 8'h04;
    localparam logic [7:0]  IMG_ALARM       = 8'h06;
    localparam logic [7:0]  IMG_RESULT      = 8'h08;
    localparam logic [7:0]  IMG_ID          = 8'h0A;
    localparam logic [7:0]  IMG_LEN         = 8'h0C;
    localparam logic [7:0]  IMG_DATA        = 8'h0E;
    localparam logic [7:0]  IMG_DATA_LAST   = 8'h8D;
    localparam int          ST_SETUP        = 3;
    localparam int          ST_BUSY         = 1;
    localparam int          ST_TRIGGER      = 0;
    localparam int          RES_PASS        = 0;
    localparam int          RES_FAIL        = 1;

    // ----------------------------------------------------------------
    // jobs, payload and reply layout
    // ----------------------------------------------------------------
    localparam logic [7:0]  JOB_FIRST       = 8'h01;
    localparam logic [7:0]  JOB_LAST        = 8'h20;
    localparam logic [7:0]  JOB_BYTES       = 8'h04;
    localparam int          JOB_WORDS       = 128;
    localparam int          CODE_BYTES      = 4;
    localparam logic [15:0] PAYLOAD_LEN     = 16'h0008;
    localparam int          FIFO_DEPTH      = 8;
    localparam int          PREFIX_LEN      = 2;
    localparam int          RD_CODE_AT      = PREFIX_LEN;
    localparam int          RD_COMMA_AT     = RD_CODE_AT + 2 * CODE_BYTES;
    localparam int          RD_EXP_AT       = RD_COMMA_AT + 1;
    localparam int          BD_COMMA_AT     = PREFIX_LEN + 2;
    localparam int          BD_DATA_AT      = BD_COMMA_AT + 1;
    localparam logic [4:0]  ACK_LEN         = 5'd3;
    localparam logic [4:0]  RD_LEN          = 5'd19;
    localparam logic [4:0]  BD_LEN          = 5'd9;
    localparam logic [4:0]  ERR_LEN         = 5'd23;
    localparam logic [23:0]  ACK_TEXT       = "ACK";
    localparam logic [15:0]  RD_TEXT        = "RD";
    localparam logic [15:0]  BD_TEXT        = "BD";
    localparam logic [183:0] ERR_TEXT       = "ERRGetJob,Index refused";

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {MSG_ACK, MSG_RESULT, MSG_BINARY, MSG_ERROR} msg_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_stream_t;

    typedef struct packed {
        logic        setup;
        logic        busy;
        logic        trigger_ready;
        logic [15:0] running_job_number;
        logic [15:0] temperature;
        logic [15:0] alarm;
    } sensor_status_t;

    typedef struct packed {
        logic        valid;
        logic        pass;
        logic        fail;
        logic [31:0] read_code;
        logic [31:0] expected_code;
    } result_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } job_write_t;

endpackage

// ==== core/byte_fifo.sv ====
// shift-register fifo whose head sits in a flip-flop
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    // filling side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // draining side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int          CW   = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0]               count;
        logic                        valid;
    } fifo_t;

    fifo_t s;
    fifo_t n;

    assign in_ready_out  = (s.count != FULL);
    assign out_valid_out = s.valid;
    assign out_data_out  = s.mem[0];

    always_comb begin
        n = s;
        if (s.valid && out_ready_in) begin
            n.mem   = s.mem >> WIDTH;
            n.count = s.count - 1'b1;
        end
        if (in_valid_in && in_ready_out) begin
            n.mem[n.count] = in_data_in;
            n.count        = n.count + 1'b1;
        end
        n.valid = (n.count != '0);
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_fifo_full_stall: assert property (s.count == FULL |-> !in_ready_out)
        else $error("fifo accepts while full");
    a_fifo_head_keep: assert property (s.valid && !out_ready_in |=> s.valid && $stable(s.mem[0]))
        else $error("fifo head lost while stalled");
endmodule
`default_nettype wire

// ==== test/tcp_peer_model.sv ====
// tcp stack model that takes reply bytes, promptly or stalling
`timescale 1ns/100ps
`default_nettype none
module tcp_peer_model
    import telegram_pkg::*;
(
    // clock and reply stream
    input  wire logic                       clock_in,
    input  wire telegram_pkg::byte_stream_t tx_in,
    input  wire logic                       slow_in,
    input  wire logic                       clear_in,
    output logic                            tx_ready_out
);
    logic [255:0] got;
    int           n;
    // stalls every other cycle when slow
    always @(negedge clock_in) begin
        tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
    end
    always @(posedge clock_in) begin
        if (clear_in) begin
            got <= '0;
            n <= 0;
        end else if (tx_in.valid === 1'b1 && tx_ready_out === 1'b1) begin
            got <= {got[247:0], tx_in.data};
            n <= n + 1;
        end
    end
endmodule
`default_nettype wire

// ==== test/sensor_telegram_interpreter_bench.sv ====
// bench sending telegrams and checking replies and the image
`timescale 1ns/100ps
`default_nettype none
module sensor_telegram_interpreter_bench;
    import telegram_pkg::*;
    logic clock_in, rst_in, rx_rdy, on_req, lock, slow, clr, tx_rdy, conn, flush_peer;
    sensor_status_t st;
    logic [15:0] cnt, port;
    logic [7:0] a, img, aid;
    byte_stream_t rx, tx;
    result_t res;
    job_write_t jw;
    int error_cnt, tests_run, clrs;
    sensor_telegram_interpreter uut (.clock_in(clock_in), .rst_in(rst_in), .rx_in(rx), .rx_ready_out(rx_rdy),
        .tx_out(tx), .tx_ready_in(tx_rdy), .conn_up_in(conn), .on_request_in(on_req), .job_lock_in(lock),
        .status_in(st), .result_in(res), .job_wr_in(jw), .stats_clear_out(clr), .result_count_out(cnt),
        .image_addr_in(a), .image_byte_out(img), .assembly_id_out(aid), .tcp_port_out(port));
    tcp_peer_model peer (.clock_in(clock_in), .tx_in(tx), .slow_in(slow), .clear_in(flush_peer),
        .tx_ready_out(tx_rdy));
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    always @(posedge clock_in) if (clr === 1'b1) clrs++;
    task check(input string nm, input logic [255:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task flush;
        @(negedge clock_in);
        flush_peer = 1'b1;
        @(negedge clock_in);
        flush_peer = 1'b0;
    endtask
    task send(input string s);
        flush();
        for (int i = 0; i < s.len(); i++) begin
            @(negedge clock_in);
            rx = {1'b1, s[i]};
            for (int k = 0; k < 40 && rx_rdy !== 1'b1; k++) @(negedge clock_in);
            if (rx_rdy !== 1'b1) begin
                error_cnt++;
                conclude();
            end
            @(posedge clock_in);
        end
        @(negedge clock_in);
        rx = {1'b0, ~rx.data};
    endtask
    task reply(input string nm, input logic [255:0] exp, input int len);
        for (int k = 0; k < 400 && peer.n < len; k++) @(negedge clock_in);
        if (peer.n < len) begin
            error_cnt++;
            conclude();
        end
        repeat (20) @(negedge clock_in);
        check(nm, peer.got, exp);
    endtask
    task pulse;
        @(negedge clock_in);
        res = {1'b1, 1'b1, 1'b0, 32'h12345678, 32'h90817263};
        @(negedge clock_in);
        res.valid = 1'b0;
    endtask
    task peek(input logic [7:0] at, input logic [7:0] exp);
        a = at;
        repeat (2) @(negedge clock_in);
        check("image", img, exp);
    endtask
    initial begin
        {rst_in, rx, on_req, lock, slow, res, jw, a, st, flush_peer} = '0;
        conn = 1'b1;
        rst_in = 1'b1;
        repeat (10) @(negedge clock_in);
        rst_in = 1'b0;
        repeat (2) @(negedge clock_in);
        check("assembly", aid, 8'h66);
        check("port", port, 16'hC350);
        send("CS\r");
        reply("ack", "ACK\r\n", 5);
        check("clear", clrs, 1);
        slow = 1'b1;
        st = {1'b1, 1'b0, 1'b1, 16'h0007, 16'h0029, 16'h0100};
        flush();
        pulse();
        reply("auto", "RD12345678,90817263\r\n", 21);
        peek(8'h00, 8'h09);
        peek(8'h02, 8'h07);
        peek(8'h04, 8'h29);
        peek(8'h07, 8'h01);
        peek(8'h0A, 8'h01);
        peek(8'h0B, 8'h00);
        peek(8'h0C, 8'h08);
        peek(8'h0E, 8'h12);
        peek(8'h15, 8'h63);
        peek(8'h16, 8'h00);
        on_req = 1'b1;
        flush();
        pulse();
        repeat (40) @(negedge clock_in);
        check("quiet", peer.n, 0);
        send("GD\n");
        reply("get", "ACK\r\nRD12345678,90817263\r\n", 26);
        on_req = 1'b0;
        conn = 1'b0;
        flush();
        pulse();
        repeat (40) @(negedge clock_in);
        check("offline", peer.n, 0);
        conn = 1'b1;
        check("results", cnt, 16'h0003);
        peek(8'h0A, 8'h03);
        send("CS\r\n");
        reply("ack2", "ACK\r\n", 5);
        check("cleared", cnt, 16'h0000);
        check("clears", clrs, 2);
        for (int b = 0; b < 4; b++) begin
            @(negedge clock_in);
            jw = {1'b1, 7'(b), 8'h41 + 8'(b)};
        end
        @(negedge clock_in);
        jw.valid = 1'b0;
        lock = 1'b1;
        send("GJ1\r\n");
        reply("locked", {ERR_TEXT, 16'h0D0A}, 25);
        lock = 1'b0;
        send("gj21\r");
        send("GJ21\r");
        reply("range", {ERR_TEXT, 16'h0D0A}, 25);
        send("GJ01\r");
        reply("job", "BD04,ABCD\r\n", 11);
        conclude();
    end
endmodule
`default_nettype wire
